// ===== hw/jtld_pkg.sv
// Shared constants and types of the lane demapper and its transmitter end.
// Assumes both ends run on one frame clock and move one whole frame per cycle.
`default_nettype none
package jtld_pkg;
	localparam int LANES     = 16;
	localparam int LANE_W    = 128;
	localparam int SAMPLES   = 80;
	localparam int SAMPLE_W  = 16;
	localparam int NARROW_W  = 12;
	localparam int SLOTS     = 5;
	localparam int SEL_W     = 4;
	localparam int FMT_W     = 5;
	localparam int NARROW_LO = SAMPLE_W - NARROW_W;

	typedef logic [FMT_W-1:0]                  jtld_format_t;
	typedef logic [LANES-1:0][SEL_W-1:0]       jtld_lane_sel_t;
	typedef logic [LANES-1:0][LANE_W-1:0]      jtld_lanes_t;
	typedef logic [SAMPLES-1:0][SAMPLE_W-1:0]  jtld_samples_t;
	typedef logic [LANES-1:0]                  jtld_lane_mask_t;

	localparam jtld_format_t FMT_3  = 5'h03;
	localparam jtld_format_t FMT_4  = 5'h04;
	localparam jtld_format_t FMT_5  = 5'h05;
	localparam jtld_format_t FMT_6  = 5'h06;
	localparam jtld_format_t FMT_7  = 5'h07;
	localparam jtld_format_t FMT_8  = 5'h08;
	localparam jtld_format_t FMT_9  = 5'h09;
	localparam jtld_format_t FMT_10 = 5'h0A;

	localparam jtld_lane_mask_t MASK_16 = 16'hFFFF;
	localparam jtld_lane_mask_t MASK_12 = 16'h0FFF;
	localparam jtld_lane_mask_t MASK_8  = 16'h00FF;
	localparam jtld_lane_mask_t MASK_4  = 16'h000F;
	localparam jtld_lane_mask_t MASK_2  = 16'h0003;
	localparam jtld_lane_mask_t MASK_1  = 16'h0001;
	localparam jtld_lane_mask_t MASK_0  = 16'h0000;

	// Logical lanes a format carries data on; all others are don't-care
	function automatic jtld_lane_mask_t lanes_used(input jtld_format_t f);
		case (f)
			FMT_3, FMT_8, FMT_10: lanes_used = MASK_16;
			FMT_4:                lanes_used = MASK_8;
			FMT_5:                lanes_used = MASK_4;
			FMT_6:                lanes_used = MASK_2;
			FMT_7:                lanes_used = MASK_1;
			FMT_9:                lanes_used = MASK_12;
			default:              lanes_used = MASK_0;
		endcase
	endfunction
endpackage
`default_nettype wire

// ===== hw/jtld_link_if.sv
// Frame-parallel link between the transmitter end and the demapper.
// Assumes one frame per clock on each lane, octet 0 in the top byte.
`timescale 1ns/1ps
`default_nettype none
interface jtld_link_if (
	input wire logic SYS_CLK
);
	import jtld_pkg::*;
	jtld_lanes_t lane;
	logic        frame_valid;

	modport tx (
		input  SYS_CLK,
		output lane,
		output frame_valid
	);
	modport rx (
		input SYS_CLK,
		input lane,
		input frame_valid
	);
endinterface
`default_nettype wire

// ===== hw/jtld_tx_mapper.sv
// Transmitter end: packs one frame of samples onto the logical lanes.
// Assumes the user presents a whole frame of samples with a valid strobe.
`timescale 1ns/1ps
`default_nettype none
module jtld_tx_mapper (
	input  wire logic                    SYS_CLK,
	input  wire logic                    RESET,
	jtld_link_if.tx                      LINK,
	input  wire jtld_pkg::jtld_format_t  LINK_FORMAT_SELECT,
	input  wire jtld_pkg::jtld_samples_t SAMPLE_DATA,
	input  wire logic                    SAMPLE_VALID
);
	import jtld_pkg::*;

	jtld_lanes_t next_lane;
	wire         fmt_known = (lanes_used(LINK_FORMAT_SELECT) != MASK_0);

	// Octet pairs of consecutive samples, first sample in octet 0
	function automatic logic [LANE_W-1:0] pack16(input jtld_samples_t s, input int base, input int cnt);
		logic [LANE_W-1:0] r;
		r = '0;
		for (int p = 0; p < cnt; p++) begin
			if (base + p < SAMPLES) begin
				r[LANE_W-1-SAMPLE_W*p -: SAMPLE_W] = s[base+p];
			end
		end
		return r;
	endfunction

	// Five 12-bit slots, then a zero tail and unused octets
	function automatic logic [LANE_W-1:0] pack12(input jtld_samples_t s, input int base, input int step);
		logic [LANE_W-1:0] r;
		r = '0;
		for (int j = 0; j < SLOTS; j++) begin
			r[LANE_W-1-NARROW_W*j -: NARROW_W] = s[base+step*j][SAMPLE_W-1:NARROW_LO];
		end
		return r;
	endfunction

	for (genvar l = 0; l < LANES; l++) begin : g_lane
		logic [LANE_W-1:0] w3, w4, w5, w6, w7, w8, w9, w10;
		assign w3 = pack16(SAMPLE_DATA, l, 1);
		assign w4 = (l < 8) ? pack16(SAMPLE_DATA, l, 1) : '0;
		assign w5 = (l < 4) ? pack16(SAMPLE_DATA, 2*l, 2) : '0;
		assign w6 = (l < 2) ? pack16(SAMPLE_DATA, 4*l, 4) : '0;
		assign w7 = (l < 1) ? pack16(SAMPLE_DATA, 0, 8) : '0;
		assign w8 = pack12(SAMPLE_DATA, l, 16);
		assign w10 = (l < 8) ? pack12(SAMPLE_DATA, l, 8) : pack12(SAMPLE_DATA, 32 + l, 8);
		if (l < 12) begin : g_nine
			localparam int B = 4 * (l / 3);
			if (l % 3 == 0) begin : g_r0
				assign w9 = {SAMPLE_DATA[B][15:4], SAMPLE_DATA[B+1][15:12], 112'h0};
			end else if (l % 3 == 1) begin : g_r1
				assign w9 = {SAMPLE_DATA[B+1][11:4], SAMPLE_DATA[B+2][15:8], 112'h0};
			end else begin : g_r2
				assign w9 = {SAMPLE_DATA[B+2][7:4], SAMPLE_DATA[B+3][15:4], 112'h0};
			end
		end else begin : g_idle
			assign w9 = '0;
		end
		assign next_lane[l] = (LINK_FORMAT_SELECT == FMT_3)  ? w3  :
		                      (LINK_FORMAT_SELECT == FMT_4)  ? w4  :
		                      (LINK_FORMAT_SELECT == FMT_5)  ? w5  :
		                      (LINK_FORMAT_SELECT == FMT_6)  ? w6  :
		                      (LINK_FORMAT_SELECT == FMT_7)  ? w7  :
		                      (LINK_FORMAT_SELECT == FMT_8)  ? w8  :
		                      (LINK_FORMAT_SELECT == FMT_9)  ? w9  :
		                      (LINK_FORMAT_SELECT == FMT_10) ? w10 : '0;
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			LINK.lane        <= '0;
			LINK.frame_valid <= 1'b0;
		end else begin
			LINK.lane        <= next_lane;
			// Unknown formats send nothing rather than garbage
			LINK.frame_valid <= SAMPLE_VALID & fmt_known;
		end
	end
endmodule
`default_nettype wire

// ===== hw/jtld_rx_demapper.sv
// Device end: selects logical lanes from physical ones and unpacks samples.
// Assumes the link runs on SYS_CLK and the transmitter uses the same format.
`timescale 1ns/1ps
`default_nettype none
module jtld_rx_demapper (
	input  wire logic                     SYS_CLK,
	input  wire logic                     RESET,
	jtld_link_if.rx                       LINK,
	input  wire jtld_pkg::jtld_format_t   LINK_FORMAT_SELECT,
	input  wire jtld_pkg::jtld_lane_sel_t LOGICAL_LANE_SOURCE_SELECT,
	output var  jtld_pkg::jtld_samples_t  SAMPLE_DATA,
	output var  logic                     SAMPLE_VALID,
	output var  jtld_pkg::jtld_lane_mask_t ACTIVE_LANES,
	output var  logic                     FORMAT_ERROR
);
	import jtld_pkg::*;

	jtld_lanes_t     logical;
	jtld_lanes_t     next_logical;
	jtld_format_t    fmt_q;
	logic            frame_seen;
	jtld_samples_t   next_sample;
	jtld_lane_mask_t used_now;
	wire             fmt_known = (lanes_used(LINK_FORMAT_SELECT) != MASK_0);

	assign used_now = lanes_used(LINK_FORMAT_SELECT);

	function automatic logic [SAMPLE_W-1:0] pick16(input jtld_lanes_t w, input int lane, input int pair);
		return w[lane][LANE_W-1-SAMPLE_W*pair -: SAMPLE_W];
	endfunction

	// 12-bit slot, left-justified in the 16-bit sample; the tail nibble is never a slot
	function automatic logic [SAMPLE_W-1:0] pick12(input jtld_lanes_t w, input int lane, input int slot);
		return {w[lane][LANE_W-1-NARROW_W*slot -: NARROW_W], 4'h0};
	endfunction

	// Lane crossbar; unused logical lanes are zeroed so their content cannot leak
	for (genvar l = 0; l < LANES; l++) begin : g_xbar
		wire [LANE_W-1:0] src = LINK.lane[LOGICAL_LANE_SOURCE_SELECT[l]];
		assign next_logical[l] = used_now[l] ? src : '0;
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			logical    <= '0;
			fmt_q      <= FMT_3;
			frame_seen <= 1'b0;
		end else begin
			logical    <= next_logical;
			fmt_q      <= LINK_FORMAT_SELECT;
			frame_seen <= LINK.frame_valid & fmt_known;
		end
	end

	// One output sample per index; mapping per format is fixed wiring
	for (genvar i = 0; i < SAMPLES; i++) begin : g_smp
		logic [SAMPLE_W-1:0] w16, w8, w9, w10;
		if (i < 16) begin : g_wide
			assign w16 = (fmt_q == FMT_3) ? pick16(logical, i, 0) :
			             (i >= 8)         ? '0 :
			             (fmt_q == FMT_4) ? pick16(logical, i, 0) :
			             (fmt_q == FMT_5) ? pick16(logical, i / 2, i % 2) :
			             (fmt_q == FMT_6) ? pick16(logical, i / 4, i % 4) :
			             (fmt_q == FMT_7) ? pick16(logical, 0, i) : '0;
			localparam int B = 3 * (i / 4);
			if (i % 4 == 0) begin : g_r0
				assign w9 = {logical[B][127:116], 4'h0};
			end else if (i % 4 == 1) begin : g_r1
				assign w9 = {logical[B][115:112], logical[B+1][127:120], 4'h0};
			end else if (i % 4 == 2) begin : g_r2
				assign w9 = {logical[B+1][119:112], logical[B+2][127:124], 4'h0};
			end else begin : g_r3
				assign w9 = {logical[B+2][123:112], 4'h0};
			end
		end else begin : g_narrow
			assign w16 = '0;
			assign w9  = '0;
		end
		assign w8 = pick12(logical, i % 16, i / 16);
		if (i < 40) begin : g_inph
			assign w10 = pick12(logical, i % 8, i / 8);
		end else begin : g_quad
			assign w10 = pick12(logical, 8 + (i - 40) % 8, (i - 40) / 8);
		end
		assign next_sample[i] = (fmt_q == FMT_8)  ? w8  :
		                        (fmt_q == FMT_9)  ? w9  :
		                        (fmt_q == FMT_10) ? w10 : w16;
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			SAMPLE_DATA  <= '0;
			SAMPLE_VALID <= 1'b0;
			ACTIVE_LANES <= MASK_0;
			FORMAT_ERROR <= 1'b0;
		end else begin
			// Data follows the frame strobe; stale samples hold between frames
			if (frame_seen) begin
				SAMPLE_DATA <= next_sample;
			end
			SAMPLE_VALID <= frame_seen;
			ACTIVE_LANES <= used_now;
			// Frames under an unsupported selection are dropped and flagged
			FORMAT_ERROR <= LINK.frame_valid & ~fmt_known;
		end
	end
endmodule
`default_nettype wire

// ===== sim/jtld_assertions.sv
// Concurrent checks on the link between the two ends and on the demapper's outputs.
// Assumes one frame clock and a synchronous active-high reset shared by both ends.
`timescale 1ns/1ps
`default_nettype none
module jtld_assertions (
	input wire logic                      SYS_CLK,
	input wire logic                      RESET,
	input wire jtld_pkg::jtld_lanes_t     lane,
	input wire logic                      frame_valid,
	input wire jtld_pkg::jtld_format_t    LINK_FORMAT_SELECT,
	input wire logic                      SAMPLE_VALID,
	input wire jtld_pkg::jtld_lane_mask_t ACTIVE_LANES,
	input wire logic                      FORMAT_ERROR
);
	import jtld_pkg::*;
	wire logic known;
	assign known = LINK_FORMAT_SELECT >= FMT_3 && LINK_FORMAT_SELECT <= FMT_10;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	frame_answer_a: assert property (frame_valid && known |-> ##2 SAMPLE_VALID)
		else $error("frame gave no samples");
	answer_cause_a: assert property (SAMPLE_VALID |-> $past(frame_valid, 2) && $past(known, 2))
		else $error("samples without a frame");
	bad_format_a: assert property (frame_valid && !known |-> ##[1:2] FORMAT_ERROR)
		else $error("unknown format not flagged");
	bad_drop_a: assert property (frame_valid && !known |-> ##2 !SAMPLE_VALID)
		else $error("unknown format frame delivered");
	mask_twelve_a: assert property (LINK_FORMAT_SELECT == FMT_9 |=> ACTIVE_LANES == MASK_12)
		else $error("lane mask wrong for twelve lanes");
	mask_eight_a: assert property (LINK_FORMAT_SELECT == FMT_4 |=> ACTIVE_LANES == MASK_8)
		else $error("lane mask wrong for eight lanes");
	tail_zero_a: assert property (frame_valid && LINK_FORMAT_SELECT == FMT_8 |-> lane[0][67:64] == 4'h0)
		else $error("tail bits not zero");
	reset_quiet_a: assert property ($past(RESET) |-> !SAMPLE_VALID && !frame_valid && ACTIVE_LANES == MASK_0)
		else $error("outputs busy after reset");
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Bench: transmitter feeding the demapper end to end, plus a second demapper on a bench-driven link.
// Assumes frames reach samples two edges after the link and unknown formats flag an error.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin err_total++; \
	$display("wrong value at %0t: %s", $time, m); end end
module tb;
	import jtld_pkg::*;
	typedef struct packed { jtld_format_t f; logic [7:0] n; logic [3:0] per; jtld_lane_mask_t m; } jtld_row_t;
	logic            clk, rst, svalid, rvalid, rerr, rvalid2, rerr2, seen;
	jtld_format_t    fmt, fmt2;
	jtld_lane_sel_t  sel, sel2;
	jtld_samples_t   sdata, rdata, rdata2;
	jtld_lane_mask_t ract;
	int              err_total, tests_run;
	// Samples delivered, samples per lane and lanes used; a zero per-lane count marks the 12-bit formats
	jtld_row_t rows [8] = '{'{FMT_3, 8'h10, 4'h1, MASK_16}, '{FMT_4, 8'h08, 4'h1, MASK_8},
		'{FMT_5, 8'h08, 4'h2, MASK_4}, '{FMT_6, 8'h08, 4'h4, MASK_2}, '{FMT_7, 8'h08, 4'h8, MASK_1},
		'{FMT_8, 8'h50, 4'h0, MASK_16}, '{FMT_9, 8'h10, 4'h0, MASK_12}, '{FMT_10, 8'h50, 4'h0, MASK_16}};
	jtld_link_if link (.SYS_CLK(clk));
	jtld_link_if link2 (.SYS_CLK(clk));
	jtld_tx_mapper u_jtld_tx_mapper (.SYS_CLK(clk), .RESET(rst), .LINK(link), .LINK_FORMAT_SELECT(fmt),
		.SAMPLE_DATA(sdata), .SAMPLE_VALID(svalid));
	jtld_rx_demapper u_jtld_rx_demapper (.SYS_CLK(clk), .RESET(rst), .LINK(link), .LINK_FORMAT_SELECT(fmt),
		.LOGICAL_LANE_SOURCE_SELECT(sel), .SAMPLE_DATA(rdata), .SAMPLE_VALID(rvalid), .ACTIVE_LANES(ract),
		.FORMAT_ERROR(rerr));
	jtld_rx_demapper u_jtld_rx_demapper_2 (.SYS_CLK(clk), .RESET(rst), .LINK(link2), .LINK_FORMAT_SELECT(fmt2),
		.LOGICAL_LANE_SOURCE_SELECT(sel2), .SAMPLE_DATA(rdata2), .SAMPLE_VALID(rvalid2), .ACTIVE_LANES(),
		.FORMAT_ERROR(rerr2));
	jtld_assertions u_jtld_assertions (.SYS_CLK(clk), .RESET(rst), .lane(link.lane),
		.frame_valid(link.frame_valid), .LINK_FORMAT_SELECT(fmt), .SAMPLE_VALID(rvalid),
		.ACTIVE_LANES(ract), .FORMAT_ERROR(rerr));
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	// Whole run is under a hundred cycles
	initial begin
		#20000;
		err_total++;
		finish_test();
	end
	initial begin
		int i;
		int l;
		logic [15:0] e;
		jtld_row_t r;
		rst = 1;
		svalid = 0;
		fmt = FMT_3;
		fmt2 = FMT_8;
		sdata = '0;
		link2.lane = '0;
		link2.frame_valid = 0;
		err_total = 0;
		tests_run = 0;
		for (l = 0; l < LANES; l++) begin
			sel[l] = SEL_W'(l);
			sel2[l] = SEL_W'(LANES - 1 - l);
		end
		repeat (12) @(negedge clk);
		rst = 0;
		foreach (rows[k]) begin
			r = rows[k];
			fmt = r.f;
			for (i = 0; i < SAMPLES; i++) sdata[i] = 16'hA5C3 ^ 16'(i * 263 + k * 4099);
			svalid = 1;
			@(negedge clk);
			svalid = 0;
			`CHK(link.frame_valid, 1'b1, "no frame on link")
			for (i = 0; i < r.n && r.per != 0; i++) begin
				l = i / r.per;
				e = link.lane[l][127 - 16 * (i % r.per) -: 16];
				`CHK(e, sdata[i], "16-bit lane packing")
			end
			for (i = 0; i < SAMPLES && r.f == FMT_8; i++) begin
				e = {4'h0, link.lane[i % 16][127 - 12 * (i / 16) -: 12]};
				`CHK(e[11:0], sdata[i][15:4], "12-bit slot packing")
			end
			for (i = 0; i < 4 && r.f == FMT_9; i++) begin
				`CHK(link.lane[3 * i][127:112], {sdata[4 * i][15:4], sdata[4 * i + 1][15:12]}, "pack a")
				`CHK(link.lane[3 * i + 1][127:112], {sdata[4 * i + 1][11:4], sdata[4 * i + 2][15:8]}, "pack b")
				`CHK(link.lane[3 * i + 2][127:112], {sdata[4 * i + 2][7:4], sdata[4 * i + 3][15:4]}, "pack c")
			end
			repeat (2) @(negedge clk);
			`CHK(rvalid, 1'b1, "no samples out")
			`CHK(ract, r.m, "active lane mask")
			for (i = 0; i < SAMPLES; i++) begin
				e = i < r.n ? (r.per == 0 ? sdata[i] & 16'hFFF0 : sdata[i]) : 16'h0000;
				`CHK(rdata[i], e, "demapped sample")
			end
		end
		// Selection turning unsupported under a frame already on the link: dropped, flagged, old samples kept
		fmt = FMT_4;
		svalid = 1;
		@(negedge clk);
		svalid = 0;
		fmt = 5'h0B;
		@(negedge clk);
		`CHK(rerr, 1'b1, "dropped frame not flagged")
		@(negedge clk);
		`CHK(rvalid, 1'b0, "dropped frame delivered")
		`CHK(rerr, 1'b0, "error flag held too long")
		`CHK(rdata[0], sdata[0] & 16'hFFF0, "dropped frame reached samples")
		// Reversed routing, all-ones tails and junk on unused lanes, then back-to-back frames
		for (l = 0; l < LANES; l++) begin
			link2.lane[15 - l] = {LANE_W{1'b1}};
			for (i = 0; i < SLOTS; i++) link2.lane[15 - l][127 - 12 * i -: 12] = sdata[l + 16 * i][15:4];
		end
		link2.frame_valid = 1;
		@(negedge clk);
		fmt2 = FMT_4;
		for (l = 0; l < 8; l++) link2.lane[15 - l][127:112] = sdata[l];
		@(negedge clk);
		`CHK(rvalid2, 1'b1, "no samples on routed link")
		for (i = 0; i < SAMPLES; i++) `CHK(rdata2[i], sdata[i] & 16'hFFF0, "routed 12-bit sample")
		fmt2 = 5'h0B;
		@(negedge clk);
		for (i = 0; i < SAMPLES; i++) `CHK(rdata2[i], i < 8 ? sdata[i] : 16'h0000, "unused lane leaked")
		link2.frame_valid = 0;
		seen = rerr2;
		@(negedge clk);
		seen = seen | rerr2;
		`CHK(seen, 1'b1, "unknown format not flagged")
		`CHK(rvalid2, 1'b0, "unknown format delivered")
		// Mid-run reset with a frame pending; the first edge after release takes it
		fmt = FMT_5;
		svalid = 1;
		rst = 1;
		repeat (2) @(negedge clk);
		`CHK(link.frame_valid, 1'b0, "link busy in reset")
		`CHK(rvalid, 1'b0, "samples in reset")
		`CHK(ract, MASK_0, "lane mask in reset")
		`CHK(rerr, 1'b0, "error flag in reset")
		`CHK(rdata, '0, "samples not cleared")
		rst = 0;
		@(negedge clk);
		svalid = 0;
		`CHK(link.frame_valid, 1'b1, "first frame after reset lost")
		repeat (2) @(negedge clk);
		`CHK(rvalid, 1'b1, "no samples after reset")
		for (i = 0; i < 8; i++) `CHK(rdata[i], sdata[i], "first frame after reset")
		finish_test();
	end
endmodule
`default_nettype wire
